// [hw/nvacc_top.sv]
`timescale 1ns/100ps
// Function
// - Write starts with slave address, R/W low, then one word-address byte.
// - Acknowledge every received data byte while write-protect is low; unlimited sequential bytes per operation.
// - Sequential write address wraps from top location to zero.
// - No write delay; new operations accepted immediately, always ready.
// - Byte committed at its eighth bit, before acknowledge; earlier START/STOP cancels.
// - No page buffer; each byte written to array individually.
// - Write-protect high: data bytes to protected locations are not acknowledged.
// - Protected write attempt leaves the address counter unchanged.
// - Write-protect low disables protection; an open pin reads low.
// - Read request has R/W high; data shifts out on next clock.
// - Read address is page bit over the latched low eight bits.
// - Each master acknowledge outputs next byte; address advances every byte.
// - Read address wraps from top location to zero.
// - Random read: write address byte, then repeated START with read.
// - Slave address: type, two select bits matching pins, page, R/W.
// - Address latch increments after each unprotected data byte, before the acknowledge slot.
// - All bytes transfer most significant bit first.
// - STOP aborts any operation in progress immediately.
module nvacc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ce,
    // Serial bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Straps
    input wire logic wp,
    input wire logic [1:0] device_select_pins
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    nvacc_pkg::nvacc_line_t line_s1_reg, line_s2_reg, line_s3_reg;
    logic wp_s1_reg, wp_s2_reg;
    logic [1:0] sel_s1_reg, sel_s2_reg;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            line_s1_reg <= nvacc_pkg::LINE_RST;
            line_s2_reg <= nvacc_pkg::LINE_RST;
            line_s3_reg <= nvacc_pkg::LINE_RST;
            wp_s1_reg <= 1'b0;
            wp_s2_reg <= 1'b0;
            sel_s1_reg <= 2'h0;
            sel_s2_reg <= 2'h0;
        end else if (ce) begin
            line_s1_reg <= '{scl: scl_i, sda: sda_i};
            line_s2_reg <= line_s1_reg;
            line_s3_reg <= line_s2_reg;
            wp_s1_reg <= wp;
            wp_s2_reg <= wp_s1_reg;
            sel_s1_reg <= device_select_pins;
            sel_s2_reg <= sel_s1_reg;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, sda_bit;
    assign scl_rise = ce & line_s2_reg.scl & ~line_s3_reg.scl;
    assign scl_fall = ce & ~line_s2_reg.scl & line_s3_reg.scl;
    assign start_det = ce & line_s2_reg.scl & line_s3_reg.scl & line_s3_reg.sda & ~line_s2_reg.sda;
    assign stop_det = ce & line_s2_reg.scl & line_s3_reg.scl & ~line_s3_reg.sda & line_s2_reg.sda;
    assign sda_bit = line_s2_reg.sda;

    // ------------------------------------------------------------
    // Protocol engine and array
    // ------------------------------------------------------------
    nvacc_pkg::nvacc_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
    logic [nvacc_pkg::ADDR_W-1:0] addr_reg, addr_next, mem_ra;
    logic page_reg, page_next, rw_reg, rw_next, ack_ok_reg, ack_ok_next;
    logic sda_oe_n_reg, sda_oe_n_next, sda_o_reg;
    logic [7:0] rx_byte, mem_wd, mem_q;
    logic addr_match, mem_we;
    logic [7:0] mem [nvacc_pkg::DEPTH];
    // Written straight from the shifter; nothing is staged for later.
    always_ff @(posedge ref_clk) begin
        if (ce && mem_we) begin
            mem[addr_reg] <= mem_wd;
        end
    end
    // The read address depends on registers alone, so the next-state logic never loops on it.
    assign mem_ra = (state_reg == nvacc_pkg::ST_DEVACK) ? {page_reg, addr_reg[7:0]}
                    : addr_reg;
    assign mem_q = mem[mem_ra];
    assign rx_byte = {shift_reg[6:0], sda_bit};
    assign addr_match = (shift_reg[nvacc_pkg::SA_TYPE_HI:nvacc_pkg::SA_TYPE_LO]
                         == nvacc_pkg::DEV_TYPE)
                        && (shift_reg[nvacc_pkg::SA_SEL_HI:nvacc_pkg::SA_SEL_LO]
                         == sel_s2_reg);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        tx_next = tx_reg;
        addr_next = addr_reg;
        page_next = page_reg;
        rw_next = rw_reg;
        ack_ok_next = ack_ok_reg;
        sda_oe_n_next = sda_oe_n_reg;
        mem_we = 1'b0;
        mem_wd = rx_byte;
        if (stop_det) begin
            state_next = nvacc_pkg::ST_IDLE;
            sda_oe_n_next = 1'b1;
        end else if (start_det) begin
            // A repeated START also abandons a pending write.
            state_next = nvacc_pkg::ST_DEVADDR;
            cnt_next = nvacc_pkg::CNT_RST;
            sda_oe_n_next = 1'b1;
        end else begin
            case (state_reg)
                nvacc_pkg::ST_DEVADDR, nvacc_pkg::ST_WORDADDR, nvacc_pkg::ST_WDATA: begin
                    if (scl_rise && cnt_reg != nvacc_pkg::CNT_FULL) begin
                        shift_next = rx_byte;
                        cnt_next = cnt_reg + nvacc_pkg::CNT_ONE;
                        if (cnt_reg == nvacc_pkg::CNT_LAST) begin
                            if (state_reg == nvacc_pkg::ST_WORDADDR) begin
                                addr_next = {page_reg, rx_byte};
                            end else if (state_reg == nvacc_pkg::ST_WDATA && !wp_s2_reg) begin
                                mem_we = 1'b1;
                                addr_next = addr_reg + nvacc_pkg::ADDR_ONE;
                            end
                        end
                    end else if (scl_fall && cnt_reg == nvacc_pkg::CNT_FULL) begin
                        cnt_next = nvacc_pkg::CNT_RST;
                        if (state_reg == nvacc_pkg::ST_DEVADDR) begin
                            page_next = shift_reg[nvacc_pkg::SA_PAGE];
                            rw_next = shift_reg[nvacc_pkg::SA_RW];
                            sda_oe_n_next = ~addr_match;
                            state_next = addr_match ? nvacc_pkg::ST_DEVACK : nvacc_pkg::ST_IGNORE;
                        end else if (state_reg == nvacc_pkg::ST_WORDADDR) begin
                            sda_oe_n_next = 1'b0;
                            state_next = nvacc_pkg::ST_WORDACK;
                        end else if (wp_s2_reg) begin
                            // Address held: the counter is not touched on the rise.
                            sda_oe_n_next = 1'b1;
                            state_next = nvacc_pkg::ST_IGNORE;
                        end else begin
                            sda_oe_n_next = 1'b0;
                            state_next = nvacc_pkg::ST_WDACK;
                        end
                    end
                end
                nvacc_pkg::ST_DEVACK: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            addr_next = mem_ra;
                            sda_oe_n_next = mem_q[nvacc_pkg::BYTE_MSB];
                            tx_next = {mem_q[6:0], 1'b0};
                            state_next = nvacc_pkg::ST_RDATA;
                        end else begin
                            sda_oe_n_next = 1'b1;
                            state_next = nvacc_pkg::ST_WORDADDR;
                        end
                    end
                end
                nvacc_pkg::ST_WORDACK, nvacc_pkg::ST_WDACK: begin
                    if (scl_fall) begin
                        sda_oe_n_next = 1'b1;
                        state_next = nvacc_pkg::ST_WDATA;
                    end
                end
                nvacc_pkg::ST_RDATA: begin
                    if (scl_rise && cnt_reg != nvacc_pkg::CNT_FULL) begin
                        cnt_next = cnt_reg + nvacc_pkg::CNT_ONE;
                        if (cnt_reg == nvacc_pkg::CNT_LAST) begin
                            addr_next = addr_reg + nvacc_pkg::ADDR_ONE;
                        end
                    end else if (scl_fall) begin
                        if (cnt_reg == nvacc_pkg::CNT_FULL) begin
                            sda_oe_n_next = 1'b1;
                            state_next = nvacc_pkg::ST_RDACK;
                        end else begin
                            sda_oe_n_next = tx_reg[nvacc_pkg::BYTE_MSB];
                            tx_next = {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                nvacc_pkg::ST_RDACK: begin
                    if (scl_rise) begin
                        ack_ok_next = ~sda_bit;
                    end else if (scl_fall) begin
                        cnt_next = nvacc_pkg::CNT_RST;
                        if (ack_ok_reg) begin
                            // Without a no-acknowledge the next byte is driven.
                            sda_oe_n_next = mem_q[nvacc_pkg::BYTE_MSB];
                            tx_next = {mem_q[6:0], 1'b0};
                            state_next = nvacc_pkg::ST_RDATA;
                        end else begin
                            sda_oe_n_next = 1'b1;
                            state_next = nvacc_pkg::ST_IGNORE;
                        end
                    end
                end
                nvacc_pkg::ST_IDLE, nvacc_pkg::ST_IGNORE: begin
                    sda_oe_n_next = 1'b1;
                end
                default: begin
                    sda_oe_n_next = 1'b1;
                    state_next = nvacc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= nvacc_pkg::ST_IDLE;
            cnt_reg <= nvacc_pkg::CNT_RST;
            shift_reg <= nvacc_pkg::BYTE_RST;
            tx_reg <= nvacc_pkg::BYTE_RST;
            addr_reg <= nvacc_pkg::ADDR_RST;
            page_reg <= 1'b0;
            rw_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
            sda_o_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            tx_reg <= tx_next;
            addr_reg <= addr_next;
            page_reg <= page_next;
            rw_reg <= rw_next;
            ack_ok_reg <= ack_ok_next;
            sda_oe_n_reg <= sda_oe_n_next;
            sda_o_reg <= 1'b0;
        end
    end
    assign sda_o = sda_o_reg;
    assign sda_oe_n = sda_oe_n_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic wdata_last, wdata_ackslot;
    assign wdata_last = state_reg == nvacc_pkg::ST_WDATA && scl_rise && !start_det
                        && !stop_det && cnt_reg == nvacc_pkg::CNT_LAST;
    assign wdata_ackslot = state_reg == nvacc_pkg::ST_WDATA && scl_fall && !start_det
                           && !stop_det && cnt_reg == nvacc_pkg::CNT_FULL;
    property p_wr_ack;
        wdata_ackslot && !wp_s2_reg |=> !sda_oe_n_reg && state_reg == nvacc_pkg::ST_WDACK;
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("data byte not acknowledged");
    property p_wp_nack;
        wdata_ackslot && wp_s2_reg |=> sda_oe_n_reg && state_reg == nvacc_pkg::ST_IGNORE;
    endproperty
    a_wp_nack: assert property (p_wp_nack) else $error("protected byte acknowledged");
    property p_wp_hold;
        wdata_last && wp_s2_reg |=> $stable(addr_reg);
    endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("address moved on protect");
    property p_wr_inc;
        wdata_last && !wp_s2_reg
            |=> addr_reg == nvacc_pkg::ADDR_W'($past(addr_reg) + nvacc_pkg::ADDR_ONE);
    endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("write address not advanced");
    property p_commit;
        mem_we |-> wdata_last && !wp_s2_reg;
    endproperty
    a_commit: assert property (p_commit) else $error("write outside eighth bit");
    property p_stop;
        stop_det |=> state_reg == nvacc_pkg::ST_IDLE && sda_oe_n_reg;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_nack_release;
        state_reg == nvacc_pkg::ST_IGNORE && !start_det |=> sda_oe_n_reg [*2];
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("line driven while idle");
    property p_rd_start;
        state_reg == nvacc_pkg::ST_DEVACK && rw_reg && scl_fall && !start_det && !stop_det
            |=> state_reg == nvacc_pkg::ST_RDATA && addr_reg[nvacc_pkg::ADDR_W-1] == page_reg;
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read start address wrong");
    property p_rd_inc;
        state_reg == nvacc_pkg::ST_RDATA && scl_rise && !start_det && !stop_det
            && cnt_reg == nvacc_pkg::CNT_LAST
            |=> addr_reg == nvacc_pkg::ADDR_W'($past(addr_reg) + nvacc_pkg::ADDR_ONE);
    endproperty
    a_rd_inc: assert property (p_rd_inc) else $error("read address not advanced");
    c_write: cover property (wdata_ackslot && !wp_s2_reg);
    c_protect: cover property (wdata_ackslot && wp_s2_reg);
    c_read_ack: cover property (state_reg == nvacc_pkg::ST_RDACK && scl_fall && ack_ok_reg);
    c_wrap: cover property (wdata_last && addr_reg == {nvacc_pkg::ADDR_W{1'b1}});
endmodule

// [include/nvacc_pkg.sv]
package nvacc_pkg;

    // ------------------------------------------------------------
    // Array and address latch
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DEPTH = 512;
    localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 9'h001;

    // ------------------------------------------------------------
    // Slave address byte layout
    // ------------------------------------------------------------
    // The device type value is arbitrary.
    localparam logic [3:0] DEV_TYPE = 4'h5;
    localparam int SA_TYPE_HI = 7;
    localparam int SA_TYPE_LO = 4;
    localparam int SA_SEL_HI = 3;
    localparam int SA_SEL_LO = 2;
    localparam int SA_PAGE = 1;
    localparam int SA_RW = 0;
    localparam int BYTE_MSB = 7;

    // ------------------------------------------------------------
    // Bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_FULL = 4'h8;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DEVADDR = 4'h1,
        ST_DEVACK = 4'h2,
        ST_WORDADDR = 4'h3,
        ST_WORDACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDACK = 4'h8,
        ST_IGNORE = 4'h9
    } nvacc_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } nvacc_line_t;

    localparam nvacc_line_t LINE_RST = 2'h3;

endpackage

// [tb/nvacc_master_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Bus master model
// ----------------------------------------
// Open-drain master: sda_drv low pulls the line, high releases it to the pull-up.
// Every change lands one step after a system edge, so sampling never races.
module nvacc_master_model (
    // Clock
    input wire logic ref_clk,
    // Bus
    output logic scl,
    output logic sda_drv,
    input wire logic sda_bus
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Works from idle or from the low half of a bit, so it also serves as repeated start.
    task automatic start();
        tick(2);
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda_drv = 1'b1;
        tick(4);
    endtask

    // One bit: 8 system cycles, data set mid-low, sampled mid-high.
    task automatic xbit(input logic b, output logic seen);
        tick(2);
        sda_drv = b;
        tick(2);
        scl = 1'b1;
        tick(2);
        seen = sda_bus;
        tick(2);
        scl = 1'b0;
    endtask

    // Nine bits, first bit of out goes first; a 1 releases the line for the slave.
    task automatic xfer(input logic [8:0] out, output logic [8:0] in);
        for (int i = 8; i >= 0; i--) begin
            xbit(out[i], in[i]);
        end
    endtask
endmodule

// [tb/nvacc_top_tb.sv]
`timescale 1ns/100ps
module nvacc_top_tb;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    typedef struct {
        logic wp;
        logic page;
        logic [7:0] addr;
        logic [7:0] data;
        logic ack;
        logic [7:0] rdv;
    } nvacc_row_t;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic wp = 1'b0;
    logic [1:0] sel = 2'h2;
    logic scl;
    logic sda_drv;
    logic sda_bus;
    logic sda_o;
    logic sda_oe_n;
    logic seen_bit;
    int errors = 0;
    int num_checks = 0;
    nvacc_row_t rows[5];

    always #25 ref_clk = ~ref_clk;

    // Wired-and of both open-drain drivers over the pull-up.
    assign sda_bus = sda_drv & (sda_oe_n | sda_o);

    nvacc_master_model mst (
        .ref_clk(ref_clk),
        .scl(scl),
        .sda_drv(sda_drv),
        .sda_bus(sda_bus)
    );

    nvacc_top dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ce(1'b1),
        .scl_i(scl),
        .sda_i(sda_bus),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .wp(wp),
        .device_select_pins(sel)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] sa(input logic page, input logic rw);
        return {nvacc_pkg::DEV_TYPE, sel, page, rw};
    endfunction

    task automatic wbyte(input logic [7:0] d, input logic ack);
        logic [8:0] r;
        mst.xfer({d, 1'b1}, r);
        chk("ack", {8'h00, ack}, {8'h00, ~r[0]});
    endtask

    task automatic set_addr(input logic page, input logic [7:0] a);
        mst.start();
        wbyte(sa(page, 1'b0), 1'b1);
        wbyte(a, 1'b1);
    endtask

    task automatic wr(input logic page, input logic [7:0] a, input logic [7:0] d[$],
                      input logic ack);
        set_addr(page, a);
        foreach (d[i]) begin
            wbyte(d[i], ack);
        end
        mst.stop();
    endtask

    // Reads the queue length in bytes, acknowledging all but the last.
    task automatic rd(input logic page, input logic [7:0] e[$]);
        logic [8:0] r;
        mst.start();
        wbyte(sa(page, 1'b1), 1'b1);
        foreach (e[i]) begin
            mst.xfer({8'hFF, i == e.size() - 1}, r);
            chk("read data", {1'b0, e[i]}, {1'b0, r[8:1]});
        end
        mst.tick(4);
        chk("released", 9'h001, {8'h00, sda_oe_n});
        chk("drive level", 9'h000, {8'h00, sda_o});
        mst.stop();
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        conclude();
    end

    initial begin
        rows[0] = '{1'b0, 1'b0, 8'h00, 8'hA5, 1'b1, 8'hA5};
        rows[1] = '{1'b0, 1'b1, 8'h3C, 8'h5A, 1'b1, 8'h5A};
        rows[2] = '{1'b0, 1'b1, 8'hFF, 8'h81, 1'b1, 8'h81};
        rows[3] = '{1'b1, 1'b0, 8'h00, 8'h12, 1'b0, 8'hA5};
        rows[4] = '{1'b0, 1'b0, 8'h00, 8'h12, 1'b1, 8'h12};
        repeat (8) @(posedge ref_clk);
        chk("idle in reset", 9'h001, {8'h00, sda_oe_n});
        #1 resetn = 1'b1;
        mst.tick(4);
        foreach (rows[i]) begin
            wp = rows[i].wp;
            wr(rows[i].page, rows[i].addr, '{rows[i].data}, rows[i].ack);
            wp = 1'b0;
            set_addr(rows[i].page, rows[i].addr);
            rd(rows[i].page, '{rows[i].rdv});
        end
        // Foreign select bits and foreign type must both go unanswered.
        for (int k = 0; k < 2; k++) begin
            mst.start();
            wbyte(k == 0 ? sa(1'b0, 1'b0) ^ 8'h0C : sa(1'b0, 1'b0) ^ 8'h80, 1'b0);
            mst.stop();
        end
        wr(1'b1, 8'hFE, '{8'h11, 8'h22, 8'h33}, 1'b1);
        set_addr(1'b1, 8'hFE);
        rd(1'b1, '{8'h11, 8'h22, 8'h33});
        wr(1'b0, 8'h10, '{8'h77, 8'h88}, 1'b1);
        set_addr(1'b0, 8'h10);
        rd(1'b0, '{8'h77});
        rd(1'b0, '{8'h88});
        wr(1'b0, 8'h20, '{8'h44}, 1'b1);
        wp = 1'b1;
        wr(1'b0, 8'h20, '{8'h99}, 1'b0);
        wp = 1'b0;
        rd(1'b0, '{8'h44});
        // Stop after four data bits must leave the stored byte alone.
        wr(1'b0, 8'h30, '{8'h66}, 1'b1);
        set_addr(1'b0, 8'h30);
        for (int k = 0; k < 4; k++) begin
            mst.xbit(1'b0, seen_bit);
        end
        mst.stop();
        chk("idle after abort", 9'h001, {8'h00, sda_oe_n});
        set_addr(1'b0, 8'h30);
        rd(1'b0, '{8'h66});
        // Reset in the middle of an acknowledge releases the line and clears the latch.
        set_addr(1'b0, 8'h30);
        resetn = 1'b0;
        mst.tick(1);
        chk("released by reset", 9'h001, {8'h00, sda_oe_n});
        resetn = 1'b1;
        mst.tick(4);
        rd(1'b0, '{8'h33});
        conclude();
    end
endmodule
